// *** src/rmc_pkg.sv ***
// Package for the radio mode and modulation configuration block.
// Assumes a 32-bit APB slave with each register in one aligned word.
package rmc_pkg;

  localparam int unsigned RMC_CLK_HZ = 10_000_000;

  // Register indices; byte address is four times the index
  localparam logic [5:0] RMC_IDX_GEN_CONFIG = 6'h00;
  localparam logic [5:0] RMC_IDX_DATA_MOD_CONFIG = 6'h01;
  localparam int unsigned RMC_ADDR_W = 8;

  // General configuration field positions
  localparam int unsigned RMC_GEN_MODE_LSB = 5;
  localparam int unsigned RMC_GEN_BAND_LSB = 3;
  localparam int unsigned RMC_GEN_TUNE_LSB = 1;
  localparam int unsigned RMC_GEN_DIV_BIT = 0;

  // Data and modulation configuration field positions
  localparam int unsigned RMC_DM_MOD_LSB = 6;
  localparam int unsigned RMC_DM_DLOW_BIT = 5;
  localparam int unsigned RMC_DM_OOK_LSB = 3;
  localparam int unsigned RMC_DM_DHIGH_BIT = 2;
  localparam int unsigned RMC_DM_IF_LSB = 0;

  // Values after reset
  localparam logic [7:0] RMC_GEN_CONFIG_RST = 8'h28;
  localparam logic [7:0] RMC_DATA_MOD_CONFIG_RST = 8'h88;

  typedef enum logic [2:0] {
    RMC_MODE_SLEEP = 3'b000,
    RMC_MODE_STANDBY = 3'b001,
    RMC_MODE_SYNTH = 3'b010,
    RMC_MODE_RECEIVE = 3'b011
  } rmc_op_mode_e;

  typedef enum logic [1:0] {
    RMC_BAND_902_915 = 2'b00,
    RMC_BAND_915_928 = 2'b01,
    RMC_BAND_950_960 = 2'b10,
    RMC_BAND_RSVD = 2'b11
  } rmc_band_e;

  typedef enum logic [1:0] {
    RMC_MOD_RSVD0 = 2'b00,
    RMC_MOD_OOK = 2'b01,
    RMC_MOD_FSK = 2'b10,
    RMC_MOD_RSVD3 = 2'b11
  } rmc_mod_e;

  typedef enum logic [1:0] {
    RMC_DATA_CONTINUOUS = 2'b00,
    RMC_DATA_BUFFER = 2'b01,
    RMC_DATA_PACKET = 2'b10,
    RMC_DATA_PACKET_ALT = 2'b11
  } rmc_data_mode_e;

endpackage

// *** src/rmc_config_regs.sv ***
// Mode and modulation configuration registers behind an APB slave.
// Assumes one clock, synchronous active-low reset, and an asynchronous
// calibration-cycle strobe from the synthesizer controller.
//
// Functional notes
// - Three-bit mode: 011 receive, 010 synthesizer, 001 stand-by default, 000 sleep.
// - Two-bit band: 00 902-915, 01 915-928 default, 10 950-960/863-870, 11 reserved.
// - Each calibration cycle toggles the tuning offset bits; default 00 adds nothing.
// - Divider-set select bit; writing 1 enables the second divider set.
// - Data/modulation register at index 0x01, resets to 0x88, all bits read/write.
// - Bits 7-6 modulation: 10 FSK default, 01 OOK, others reserved.
// - Bit 5 is the data mode low bit, default zero.
// - Bit 2 is the data mode high bit, default zero.
// - Data mode comes only from high bit and low bit paired.
// - Bits 4-3 OOK threshold: 10 average, 01 peak default, 11 reserved.
// - Bits 1-0 IF attenuation: 0, 4.5, 9, 13.5 dB less gain.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps

module rmc_config_regs (
  input wire logic I_CLK_SYS,
  input wire logic I_RESET_N,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [rmc_pkg::RMC_ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_CAL_CYCLE,
  output logic [2:0] O_OP_MODE,
  output logic [1:0] O_BAND_SELECT,
  output logic [1:0] O_TUNING_OFFSET_SELECT,
  output logic O_DIVIDER_SET_SELECT,
  output logic [1:0] O_MODULATION_TYPE_SELECT,
  output logic [1:0] O_DATA_MODE,
  output logic [1:0] O_OOK_THRESHOLD_KIND,
  output logic [1:0] O_IF_ATTENUATION_SELECT
);
  import rmc_pkg::*;

  logic [7:0] gen_config;
  logic [7:0] data_mod_config;
  logic [2:0] cal_sync;
  logic cal_level;
  logic cal_event;
  logic access;
  logic write_take;
  logic hit_gen;
  logic hit_dm;
  logic mapped;
  logic [1:0] next_tune;
  logic [7:0] next_gen;

  function automatic logic addr_hits(input logic [RMC_ADDR_W-1:0] addr,
                                     input logic [5:0] idx);
    addr_hits = (addr[RMC_ADDR_W-1:2] == idx) && (addr[1:0] == 2'b00);
  endfunction

  assign hit_gen = addr_hits(I_PADDR, RMC_IDX_GEN_CONFIG);
  assign hit_dm = addr_hits(I_PADDR, RMC_IDX_DATA_MOD_CONFIG);
  assign mapped = hit_gen || hit_dm;
  // One wait state: ready rises on the second access cycle
  assign access = I_PSEL && I_PENABLE && !O_PREADY;
  assign write_take = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PSTRB[0];

  // Strobe arrives from another domain; counted when stages two and three agree
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESET_N) begin
      cal_sync <= 3'b000;
      cal_level <= 1'b0;
    end else begin
      cal_sync <= {cal_sync[1:0], I_CAL_CYCLE};
      if (cal_sync[1] == cal_sync[2]) begin
        cal_level <= cal_sync[2];
      end
    end
  end

  assign cal_event = (cal_sync[1] == cal_sync[2]) && cal_sync[2] && !cal_level;

  // Toggle applies on top of a same-cycle write so no calibration cycle is lost
  always_comb begin
    next_gen = gen_config;
    if (write_take && hit_gen) begin
      next_gen = I_PWDATA[7:0];
    end
    next_tune = next_gen[RMC_GEN_TUNE_LSB+:2];
    if (cal_event) begin
      next_tune = ~next_tune;
    end
    next_gen[RMC_GEN_TUNE_LSB+:2] = next_tune;
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESET_N) begin
      gen_config <= RMC_GEN_CONFIG_RST;
    end else begin
      gen_config <= next_gen;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESET_N) begin
      data_mod_config <= RMC_DATA_MOD_CONFIG_RST;
    end else if (write_take && hit_dm) begin
      data_mod_config <= I_PWDATA[7:0];
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESET_N) begin
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA <= 32'h0000_0000;
    end else begin
      O_PREADY <= access;
      O_PSLVERR <= access && !mapped;
      if (access && !I_PWRITE && hit_gen) begin
        O_PRDATA <= {24'h00_0000, gen_config};
      end else if (access && !I_PWRITE && hit_dm) begin
        O_PRDATA <= {24'h00_0000, data_mod_config};
      end else begin
        O_PRDATA <= 32'h0000_0000;
      end
    end
  end

  // Field outputs are registered copies; reserved codes pass through unchanged
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESET_N) begin
      O_OP_MODE <= RMC_GEN_CONFIG_RST[RMC_GEN_MODE_LSB+:3];
      O_BAND_SELECT <= RMC_GEN_CONFIG_RST[RMC_GEN_BAND_LSB+:2];
      O_TUNING_OFFSET_SELECT <= RMC_GEN_CONFIG_RST[RMC_GEN_TUNE_LSB+:2];
      O_DIVIDER_SET_SELECT <= RMC_GEN_CONFIG_RST[RMC_GEN_DIV_BIT];
      O_MODULATION_TYPE_SELECT <= RMC_DATA_MOD_CONFIG_RST[RMC_DM_MOD_LSB+:2];
      O_DATA_MODE <= {RMC_DATA_MOD_CONFIG_RST[RMC_DM_DHIGH_BIT],
                      RMC_DATA_MOD_CONFIG_RST[RMC_DM_DLOW_BIT]};
      O_OOK_THRESHOLD_KIND <= RMC_DATA_MOD_CONFIG_RST[RMC_DM_OOK_LSB+:2];
      O_IF_ATTENUATION_SELECT <= RMC_DATA_MOD_CONFIG_RST[RMC_DM_IF_LSB+:2];
    end else begin
      O_OP_MODE <= next_gen[RMC_GEN_MODE_LSB+:3];
      O_BAND_SELECT <= next_gen[RMC_GEN_BAND_LSB+:2];
      O_TUNING_OFFSET_SELECT <= next_gen[RMC_GEN_TUNE_LSB+:2];
      O_DIVIDER_SET_SELECT <= next_gen[RMC_GEN_DIV_BIT];
      O_MODULATION_TYPE_SELECT <= data_mod_config[RMC_DM_MOD_LSB+:2];
      // Bits are apart in the word; only this pair selects the mode
      O_DATA_MODE <= {data_mod_config[RMC_DM_DHIGH_BIT],
                      data_mod_config[RMC_DM_DLOW_BIT]};
      O_OOK_THRESHOLD_KIND <= data_mod_config[RMC_DM_OOK_LSB+:2];
      O_IF_ATTENUATION_SELECT <= data_mod_config[RMC_DM_IF_LSB+:2];
    end
  end

endmodule

// *** verification/rmc_config_regs_properties.sv ***
// Port assertions for the mode and modulation configuration registers.
// Assumes the bench keeps calibration pulses clear of register writes.
`timescale 1ns/1ps
module rmc_config_regs_properties (
  input wire logic I_CLK_SYS,
  input wire logic I_RESET_N,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic I_CAL_CYCLE,
  input wire logic [rmc_pkg::RMC_ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic [3:0] I_PSTRB,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic O_DIVIDER_SET_SELECT,
  input wire logic [2:0] O_OP_MODE,
  input wire logic [1:0] O_BAND_SELECT,
  input wire logic [1:0] O_TUNING_OFFSET_SELECT,
  input wire logic [1:0] O_MODULATION_TYPE_SELECT,
  input wire logic [1:0] O_DATA_MODE,
  input wire logic [1:0] O_OOK_THRESHOLD_KIND,
  input wire logic [1:0] O_IF_ATTENUATION_SELECT
);
  logic wr;
  // Strobe lane 0 gates the store, so writes without it are not expected to land
  assign wr = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PSTRB[0];
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESET_N);
  a_one_wait: assert property (I_PSEL && !I_PENABLE |=> !O_PREADY ##1 O_PREADY)
    else $error("ready not on second access cycle");
  a_err_map: assert property (I_PSEL && !I_PENABLE |=>
    ##1 O_PSLVERR == !(I_PADDR inside {8'h00, 8'h04})) else $error("wrong error answer");
  a_rdata_idle: assert property (!O_PREADY |-> O_PRDATA == 32'h0)
    else $error("stray read data");
  a_reset_dflt: assert property ($rose(I_RESET_N) |->
    {O_OP_MODE, O_BAND_SELECT, O_MODULATION_TYPE_SELECT, O_OOK_THRESHOLD_KIND} == 9'h059)
    else $error("wrong reset value");
  a_gen_fields: assert property (wr && I_PADDR == 8'h00 |-> ##2 {O_OP_MODE,
    O_BAND_SELECT, O_TUNING_OFFSET_SELECT, O_DIVIDER_SET_SELECT} == $past(I_PWDATA[7:0], 2))
    else $error("general field mismatch");
  a_mod_fields: assert property (wr && I_PADDR == 8'h04 |-> ##2
    {O_MODULATION_TYPE_SELECT, O_OOK_THRESHOLD_KIND, O_IF_ATTENUATION_SELECT} ==
    {$past(I_PWDATA[7:6], 2), $past(I_PWDATA[4:3], 2), $past(I_PWDATA[1:0], 2)})
    else $error("modulation field mismatch");
  a_dmode_pair: assert property (wr && I_PADDR == 8'h04 |-> ##2
    O_DATA_MODE == {$past(I_PWDATA[2], 2), $past(I_PWDATA[5], 2)})
    else $error("data mode mismatch");
  a_tune_flip: assert property ($rose(I_CAL_CYCLE) |-> ##[2:6]
    O_TUNING_OFFSET_SELECT == ~$past(O_TUNING_OFFSET_SELECT)) else $error("tuning not inverted");
endmodule

// *** verification/rmc_config_regs_tb.sv ***
// Self-checking bench for the mode and modulation configuration registers.
// Assumes an APB slave that answers after one wait state.
`timescale 1ns/1ps
`define CHK(g, x) begin n_tests++; if ((g) !== (x)) begin err_count++; \
  $display("BAD %0t %h %h", $time, g, x); end end
module rmc_config_regs_tb;
  logic I_CLK_SYS = 1'b0, I_RESET_N = 1'b0, I_PSEL = 1'b0, I_PENABLE = 1'b0, I_PWRITE = 1'b0;
  logic I_CAL_CYCLE = 1'b0, O_PREADY, O_PSLVERR, O_DIVIDER_SET_SELECT, e;
  logic [7:0] I_PADDR = 8'h00;
  logic [31:0] I_PWDATA = 32'h0, O_PRDATA, q;
  logic [3:0] I_PSTRB = 4'hf;
  logic [2:0] O_OP_MODE;
  logic [1:0] O_BAND_SELECT, O_TUNING_OFFSET_SELECT, O_MODULATION_TYPE_SELECT, O_DATA_MODE;
  logic [1:0] O_OOK_THRESHOLD_KIND, O_IF_ATTENUATION_SELECT;
  int err_count = 0, n_tests = 0;
  rmc_config_regs i_rmc_config_regs (
    .I_CLK_SYS(I_CLK_SYS),
    .I_RESET_N(I_RESET_N),
    .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE),
    .I_PWRITE(I_PWRITE),
    .I_PADDR(I_PADDR),
    .I_PWDATA(I_PWDATA),
    .I_PSTRB(I_PSTRB),
    .O_PRDATA(O_PRDATA),
    .O_PREADY(O_PREADY),
    .O_PSLVERR(O_PSLVERR),
    .I_CAL_CYCLE(I_CAL_CYCLE),
    .O_OP_MODE(O_OP_MODE),
    .O_BAND_SELECT(O_BAND_SELECT),
    .O_TUNING_OFFSET_SELECT(O_TUNING_OFFSET_SELECT),
    .O_DIVIDER_SET_SELECT(O_DIVIDER_SET_SELECT),
    .O_MODULATION_TYPE_SELECT(O_MODULATION_TYPE_SELECT),
    .O_DATA_MODE(O_DATA_MODE),
    .O_OOK_THRESHOLD_KIND(O_OOK_THRESHOLD_KIND),
    .O_IF_ATTENUATION_SELECT(O_IF_ATTENUATION_SELECT)
  );
  always #50 I_CLK_SYS = ~I_CLK_SYS;
  task automatic print_verdict;
    if (err_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    {I_PSEL, I_PWRITE, I_PADDR, I_PWDATA} <= {1'b1, w, a, d};
    @(posedge I_CLK_SYS);
    I_PENABLE <= 1'b1;
    // Ready and the answer are taken at the edge that completes the access
    do begin
      @(posedge I_CLK_SYS);
      n++;
    end while (O_PREADY !== 1'b1 && n < 9);
    if (O_PREADY !== 1'b1) begin
      err_count++;
      print_verdict;
    end
    {e, q} = {O_PSLVERR, O_PRDATA};
    {I_PSEL, I_PENABLE} <= 2'b00;
    // Idle edge so the next request never lands in the release step
    @(posedge I_CLK_SYS);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(q, x)
  endtask
  task automatic cal;
    I_CAL_CYCLE <= 1'b1;
    repeat (4) @(posedge I_CLK_SYS);
    I_CAL_CYCLE <= 1'b0;
    repeat (6) @(posedge I_CLK_SYS);
  endtask
  task automatic t_gen;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'h00, {24'h0, 3'(i), 2'(i % 3), 2'h0, i[0]});
      `CHK(O_OP_MODE, 3'(i))
      `CHK(O_BAND_SELECT, 2'(i % 3))
      `CHK(O_DIVIDER_SET_SELECT, i[0])
    end
  endtask
  task automatic t_dmod;
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      d = {i[0] ? 2'h1 : 2'h2, i[0], i[1] ? 2'h2 : 2'h1, i[1], 2'(i)};
      apb(1'b1, 8'h04, {24'h0, d});
      rd(8'h04, {24'h0, d});
      `CHK(O_MODULATION_TYPE_SELECT, i[0] ? 2'h1 : 2'h2)
      `CHK(O_OOK_THRESHOLD_KIND, i[1] ? 2'h2 : 2'h1)
      `CHK(O_DATA_MODE, 2'(i))
      `CHK(O_IF_ATTENUATION_SELECT, 2'(i))
    end
  endtask
  task automatic t_cal;
    apb(1'b1, 8'h00, 32'h2a);
    cal;
    rd(8'h00, 32'h2c);
    cal;
    `CHK(O_TUNING_OFFSET_SELECT, 2'h1)
  endtask
  task automatic t_err;
    apb(1'b1, 8'h08, 32'hff);
    `CHK(e, 1'b1)
    apb(1'b0, 8'h05, 32'h0);
    `CHK({e, q}, 33'h100000000)
    I_PSTRB <= 4'h0;
    apb(1'b1, 8'h04, 32'h41);
    I_PSTRB <= 4'hf;
    rd(8'h04, 32'h77);
  endtask
  initial begin
    repeat (8) @(posedge I_CLK_SYS);
    I_RESET_N <= 1'b1;
    @(posedge I_CLK_SYS);
    rd(8'h00, 32'h28);
    rd(8'h04, 32'h88);
    `CHK(O_DATA_MODE, 2'h0)
    t_gen;
    t_dmod;
    t_cal;
    t_err;
    print_verdict;
  end
endmodule
bind rmc_config_regs rmc_config_regs_properties i_rmc_config_regs_properties (
  .I_CLK_SYS(I_CLK_SYS),
  .I_RESET_N(I_RESET_N),
  .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE),
  .I_CAL_CYCLE(I_CAL_CYCLE),
  .I_PADDR(I_PADDR),
  .I_PWDATA(I_PWDATA),
  .O_PRDATA(O_PRDATA),
  .I_PSTRB(I_PSTRB),
  .O_PREADY(O_PREADY),
  .O_PSLVERR(O_PSLVERR),
  .O_DIVIDER_SET_SELECT(O_DIVIDER_SET_SELECT),
  .O_OP_MODE(O_OP_MODE),
  .O_BAND_SELECT(O_BAND_SELECT),
  .O_TUNING_OFFSET_SELECT(O_TUNING_OFFSET_SELECT),
  .O_MODULATION_TYPE_SELECT(O_MODULATION_TYPE_SELECT),
  .O_DATA_MODE(O_DATA_MODE),
  .O_OOK_THRESHOLD_KIND(O_OOK_THRESHOLD_KIND),
  .O_IF_ATTENUATION_SELECT(O_IF_ATTENUATION_SELECT)
);
